// *** bench/gpg_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Pad level: the port wins where it drives, else the outside level
module gpg_pin_model (
  input wire logic [4:0] pin_o,
  input wire logic [4:0] pin_oe,
  input wire logic [4:0] ext_val,
  output logic [4:0] pin_i
);
  assign pin_i = (pin_o & pin_oe) | (ext_val & ~pin_oe);
endmodule
`default_nettype wire

// *** bench/gpg_port_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gpg_defines.svh"
module gpg_port_bench;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [4:0] ext = 5'h0a;
  logic s2_act = 1'b0;
  logic [1:0] ov_en = 2'h0;
  logic [1:0] ov_out = 2'h0;
  logic [1:0] ov_dat = 2'h0;
  logic pready, pslverr, pu_d, pu_e, pu_j, od_s2, od_s1, od_spi, od_c2, od_c1;
  logic [31:0] prdata;
  logic [4:0] pin_i, pin_o, pin_oe;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #4 ref_clk = ~ref_clk;
  gpg_port DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .serial2_active(s2_act), .serial2_ovr_en(ov_en),
    .serial2_ovr_out(ov_out), .serial2_ovr_dat(ov_dat),
    .portd_pullup_n(pu_d), .porte_pullup_n(pu_e), .portj_pullup_n(pu_j),
    .serial2_open_drain(od_s2), .serial1_open_drain(od_s1),
    .spi_open_drain(od_spi), .capture2_open_drain(od_c2),
    .capture1_open_drain(od_c1)
  );
  gpg_pin_model pads (.pin_o(pin_o), .pin_oe(pin_oe), .ext_val(ext), .pin_i(pin_i));
  task automatic print_verdict;
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Setup on an edge, access on the next, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 600)
    begin
      fail_count++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("pullups", {pu_d, pu_e, pu_j}, 32'h7);
    chk("pin_oe", pin_oe, 32'h0);
    chk("pready", pready, 32'h1);
    apb(1'b0, `GPG_PORT_OFS, 8'h00);
    chk("port", rd, 32'hea);
    apb(1'b0, `GPG_LAT_OFS, 8'h00);
    chk("latch", rd, 32'h00);
    apb(1'b0, `GPG_DIR_OFS, 8'h00);
    chk("dir", rd, 32'h1f);
    apb(1'b1, `GPG_DIR_OFS, 8'he0);
    apb(1'b1, `GPG_LAT_OFS, 8'hf5);
    chk("od", {od_s2, od_s1, od_spi, od_c2, od_c1}, 32'h1f);
    chk("pin_oe", pin_oe, 32'h1f);
    chk("pin_o", pin_o, 32'h15);
    apb(1'b0, `GPG_LAT_OFS, 8'h00);
    chk("latch", rd, 32'hd5);
    apb(1'b0, `GPG_PORT_OFS, 8'h00);
    chk("port", rd, 32'hf5);
    apb(1'b1, `GPG_PORT_OFS, 8'h0a);
    chk("pullups", {pu_d, pu_e, pu_j}, 32'h0);
    apb(1'b0, `GPG_LAT_OFS, 8'h00);
    chk("latch", rd, 32'hca);
    apb(1'b1, `GPG_DIR_OFS, 8'he6);
    // Pin 2 forced to output against its direction bit; pin 1 forced to input, as its direction bit already sets
    @(posedge ref_clk);
    s2_act <= 1'b1;
    ov_en <= 2'b11;
    ov_out <= 2'b10;
    ov_dat <= 2'b11;
    @(posedge ref_clk);
    #1;
    chk("pin_oe", pin_oe, 32'h1d);
    chk("pin_o", pin_o & pin_oe, 32'h0c);
    apb(1'b0, `GPG_DIR_OFS, 8'h00);
    chk("dir", rd, 32'he6);
    @(posedge ref_clk);
    ov_out <= 2'b11;
    @(posedge ref_clk);
    #1;
    chk("pin_oe", pin_oe, 32'h1d);
    @(posedge ref_clk);
    ov_dat <= 2'b10;
    @(posedge ref_clk);
    #1;
    chk("pin_oe", pin_oe, 32'h1f);
    chk("pin_o", pin_o & pin_oe, 32'h0c);
    @(posedge ref_clk);
    s2_act <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("pin_oe", pin_oe, 32'h19);
    apb(1'b0, 12'h00c, 8'h00);
    chk("unmapped", rd, 32'h0);
    chk("slverr", err, 32'h1);
    apb(1'b1, 12'h00c, 8'hff);
    apb(1'b0, `GPG_LAT_OFS, 8'h00);
    chk("latch", rd, 32'hca);
    chk("slverr", err, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire

// *** src/gpg_defines.svh ***
// Operation
// R1 - Five-bit bidirectional port; each pin is read through the port register.
// R2 - Direction bit 0 drives the latch bit out; 1 makes the pin an input.
// R3 - Latch bit 7 makes serial-2 transmit/clock pin open-drain while serial-2 active.
// R4 - An enabled peripheral may force a shared pin to output or input.
// R5 - Overrides never enter the direction register; reads return software values.
// R6 - Port register bits 7,6,5 are active-low pull-up enables for ports D,E,J.
// R7 - Every reset disables all pull-ups controlled by port register upper bits.
// R8 - Direction bits 7..5 and latch bits 7..6 select peripheral open-drain outputs.
// R9 - Latch bit 5 is unimplemented: writes ignored, reads zero.
// R10 - Serial-2 transmit or sync data output overrides the port latch value.
// R11 - Software sets receive pin direction to input for asynchronous receive.
// R12 - Software sets direction to input when serial-2 uses a pin as sync input.
// R13 - Small package: port-J pull-up bit unimplemented, reads zero.
// R14 - The three pull-up control bits reset to one.
// R15 - Writing the port register updates latch bits 4 to 0.
`ifndef GPG_DEFINES_SVH
`define GPG_DEFINES_SVH
`define GPG_PORT_OFS 12'h000
`define GPG_LAT_OFS 12'h004
`define GPG_DIR_OFS 12'h008
`define GPG_PINS 5
`define GPG_PU_RST 3'h7
`define GPG_LAT_RST 5'h00
`define GPG_DIR_RST 5'h1f
`define GPG_OD_RST 3'h0
`define GPG_PULLJ_BIT 5
`define GPG_PULLE_BIT 6
`define GPG_PULLD_BIT 7
`endif

// *** src/gpg_pin_mux.sv ***
`timescale 1ns/1ps
`default_nettype none
// One pin's output path: peripheral override first, then software direction.
module gpg_pin_mux (
  input wire logic dir_bit,
  input wire logic lat_bit,
  input wire logic ovr_en,
  input wire logic ovr_out,
  input wire logic ovr_dat,
  output logic pin_oe,
  output logic pin_o
);
  always_comb
  begin
    if (ovr_en)
    begin
      pin_oe = ovr_out; // R4
      pin_o = ovr_dat; // R10
    end
    else
    begin
      pin_oe = ~dir_bit; // R2
      pin_o = lat_bit; // R2
    end
  end
endmodule
`default_nettype wire

// *** src/gpg_pkg.sv ***
package gpg_pkg;
  typedef enum logic [2:0] {
    GPG_IDLE = 3'b001,
    GPG_ACCESS = 3'b010,
    GPG_DONE = 3'b100
  } gpg_apb_state_t;
endpackage

// *** src/gpg_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gpg_defines.svh"
module gpg_port #(
  parameter bit HAS_PORTJ = 1'b1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [4:0] pin_i,
  output logic [4:0] pin_o,
  output logic [4:0] pin_oe,
  input wire logic serial2_active,
  input wire logic [1:0] serial2_ovr_en,
  input wire logic [1:0] serial2_ovr_out,
  input wire logic [1:0] serial2_ovr_dat,
  output logic portd_pullup_n,
  output logic porte_pullup_n,
  output logic portj_pullup_n,
  output logic serial2_open_drain,
  output logic serial1_open_drain,
  output logic spi_open_drain,
  output logic capture2_open_drain,
  output logic capture1_open_drain
);
  logic [2:0] pu_reg, pu_next;
  logic [4:0] lat_reg, lat_next;
  logic [4:0] dir_reg, dir_next;
  logic [1:0] uod_reg, uod_next;
  logic [2:0] pod_reg, pod_next;
  logic [4:0] pin_reg;
  logic [31:0] rd_reg, rd_next;
  logic [4:0] drv_oe, drv_o;
  logic [1:0] sh_en, sh_out, sh_dat;
  logic wr_en, rd_en, hit;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `GPG_PORT_OFS) || (a == `GPG_LAT_OFS) || (a == `GPG_DIR_OFS);
  endfunction

  // Access completes in the access phase with zero wait states
  assign pready = 1'b1;
  assign hit = is_mapped(paddr);
  assign pslverr = psel & penable & ~hit;
  assign wr_en = psel & penable & pwrite & hit & pstrb[0];
  assign rd_en = psel & ~penable & ~pwrite;

  always_comb
  begin
    pu_next = pu_reg;
    lat_next = lat_reg;
    dir_next = dir_reg;
    uod_next = uod_reg;
    pod_next = pod_reg;
    if (wr_en)
    begin
      unique case (paddr)
        `GPG_PORT_OFS:
        begin
          pu_next = pwdata[7:5]; // R6
          lat_next = pwdata[4:0]; // R15
        end
        `GPG_LAT_OFS:
        begin
          uod_next = pwdata[7:6]; // R8
          lat_next = pwdata[4:0];
        end
        `GPG_DIR_OFS:
        begin
          pod_next = pwdata[7:5]; // R8
          dir_next = pwdata[4:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  always_comb
  begin
    rd_next = rd_reg;
    if (rd_en)
    begin
      rd_next = 32'h0000_0000;
      unique case (paddr)
        `GPG_PORT_OFS:
          // Port J bit reads zero on the small package
          rd_next[7:0] = {pu_reg[2:1], pu_reg[0] & HAS_PORTJ, pin_reg}; // R1 R13
        `GPG_LAT_OFS:
          rd_next[7:0] = {uod_reg, 1'b0, lat_reg}; // R9
        `GPG_DIR_OFS:
          rd_next[7:0] = {pod_reg, dir_reg}; // R5
        default:
          rd_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pu_reg <= `GPG_PU_RST; // R7 R14
      lat_reg <= `GPG_LAT_RST;
      dir_reg <= `GPG_DIR_RST;
      uod_reg <= 2'h0;
      pod_reg <= `GPG_OD_RST;
      pin_reg <= 5'h00;
      rd_reg <= 32'h0000_0000;
    end
    else
    begin
      pu_reg <= pu_next;
      lat_reg <= lat_next;
      dir_reg <= dir_next;
      uod_reg <= uod_next;
      pod_reg <= pod_next;
      pin_reg <= pin_i; // R1
      rd_reg <= rd_next;
    end
  end
  assign prdata = rd_reg;

  // Only pins 1 and 2 are shared with serial 2
  assign sh_en = serial2_ovr_en & {2{serial2_active}};
  assign sh_out = serial2_ovr_out;
  assign sh_dat = serial2_ovr_dat;

  genvar g;
  generate
    for (g = 0; g < `GPG_PINS; g++)
    begin : g_pin
      gpg_pin_mux u_mux (
        .dir_bit(dir_reg[g]),
        .lat_bit(lat_reg[g]),
        .ovr_en((g == 1 || g == 2) ? sh_en[(g == 2) ? 1 : 0] : 1'b0),
        .ovr_out((g == 1 || g == 2) ? sh_out[(g == 2) ? 1 : 0] : 1'b0),
        .ovr_dat((g == 1 || g == 2) ? sh_dat[(g == 2) ? 1 : 0] : 1'b0),
        .pin_oe(drv_oe[g]),
        .pin_o(drv_o[g])
      );
    end
  endgenerate

  always_comb
  begin
    pin_o = drv_o;
    pin_oe = drv_oe;
    // Open-drain: drive low only, release when high
    if (uod_reg[1] && serial2_active)
    begin
      pin_oe[1] = drv_oe[1] & ~drv_o[1]; // R3
      pin_o[1] = 1'b0;
    end
  end

  assign portd_pullup_n = pu_reg[2]; // R6
  assign porte_pullup_n = pu_reg[1];
  assign portj_pullup_n = pu_reg[0] | ~HAS_PORTJ; // R13
  assign serial2_open_drain = uod_reg[1]; // R8
  assign serial1_open_drain = uod_reg[0];
  assign spi_open_drain = pod_reg[2];
  assign capture2_open_drain = pod_reg[1];
  assign capture1_open_drain = pod_reg[0];

  // Bus phase tracker; lets the checks below tell setup from access
  gpg_pkg::gpg_apb_state_t state_reg, state_next;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      gpg_pkg::GPG_IDLE:
        if (psel && !penable)
          state_next = gpg_pkg::GPG_ACCESS;
      gpg_pkg::GPG_ACCESS:
        if (psel && penable)
          state_next = gpg_pkg::GPG_DONE;
      gpg_pkg::GPG_DONE:
        if (psel && !penable)
          state_next = gpg_pkg::GPG_ACCESS;
        else
          state_next = gpg_pkg::GPG_IDLE;
      // Only reachable through an upset of the one-hot code
      default:
        state_next = gpg_pkg::GPG_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      state_reg <= gpg_pkg::GPG_IDLE;
    else
      state_reg <= state_next;
  end

  // Reset values and bus behaviour
  a_pullup_reset: assert property (@(posedge ref_clk) // R7 R14
    sys_rst |=> (portd_pullup_n && porte_pullup_n && portj_pullup_n))
    else $error("pull-ups not disabled after reset");
  a_reset_regs: assert property (@(posedge ref_clk)
    sys_rst |=> (dir_reg == `GPG_DIR_RST && lat_reg == `GPG_LAT_RST && pod_reg == `GPG_OD_RST))
    else $error("registers not at reset values");
  a_state_onehot: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $onehot(state_reg))
    else $error("bus phase code not one-hot");
  a_rd_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_reg == gpg_pkg::GPG_DONE) |-> $stable(prdata))
    else $error("read data changed after access");
  a_prdata_upper: assert property (@(posedge ref_clk) disable iff (sys_rst)
    prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_unmapped_nowrite: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (psel && penable && pwrite && !hit) |=> ($stable(lat_reg) && $stable(dir_reg) && $stable(pu_reg)))
    else $error("unmapped write changed a register");

  // Register writes and reads
  a_port_write: assert property (@(posedge ref_clk) disable iff (sys_rst) // R15
    (wr_en && paddr == `GPG_PORT_OFS) |=> (lat_reg == $past(pwdata[4:0])))
    else $error("port write missed latch");
  a_pullup_write: assert property (@(posedge ref_clk) disable iff (sys_rst) // R6
    (wr_en && paddr == `GPG_PORT_OFS) |=> ({portd_pullup_n, porte_pullup_n} == $past(pwdata[7:6])))
    else $error("pull-up control not written");
  a_lat_write: assert property (@(posedge ref_clk) disable iff (sys_rst) // R2
    (wr_en && paddr == `GPG_LAT_OFS) |=> (lat_reg == $past(pwdata[4:0])))
    else $error("latch write lost");
  a_serial_od: assert property (@(posedge ref_clk) disable iff (sys_rst) // R8
    (wr_en && paddr == `GPG_LAT_OFS) |=>
    ({serial2_open_drain, serial1_open_drain} == $past(pwdata[7:6])))
    else $error("serial open-drain control not written");
  a_periph_od: assert property (@(posedge ref_clk) disable iff (sys_rst) // R8
    (wr_en && paddr == `GPG_DIR_OFS) |=>
    ({spi_open_drain, capture2_open_drain, capture1_open_drain} == $past(pwdata[7:5])))
    else $error("peripheral open-drain control not written");
  a_dir_write: assert property (@(posedge ref_clk) disable iff (sys_rst) // R5
    (wr_en && paddr == `GPG_DIR_OFS) |=> (dir_reg == $past(pwdata[4:0])))
    else $error("direction write lost");
  a_dir_no_ovr: assert property (@(posedge ref_clk) disable iff (sys_rst) // R5
    !(wr_en && paddr == `GPG_DIR_OFS) |=> $stable(dir_reg))
    else $error("direction changed without a write");
  a_lat5_zero: assert property (@(posedge ref_clk) disable iff (sys_rst) // R9
    (psel && penable && !pwrite && paddr == `GPG_LAT_OFS) |-> prdata[5] == 1'b0)
    else $error("latch bit 5 reads one");
  a_dir_readback: assert property (@(posedge ref_clk) disable iff (sys_rst) // R5
    (psel && penable && !pwrite && paddr == `GPG_DIR_OFS) |-> prdata[4:0] == dir_reg)
    else $error("direction readback altered");
  a_portj_read: assert property (@(posedge ref_clk) disable iff (sys_rst) // R13
    (psel && penable && !pwrite && paddr == `GPG_PORT_OFS) |->
    ((prdata[5] == (portj_pullup_n & HAS_PORTJ)) && (portj_pullup_n || HAS_PORTJ)))
    else $error("port J pull-up bit wrong");
  a_pin_read: assert property (@(posedge ref_clk) disable iff (sys_rst) // R1
    !sys_rst |=> pin_reg == $past(pin_i))
    else $error("pin sample lost");

  // Pin path
  a_port_drive: assert property (@(posedge ref_clk) disable iff (sys_rst) // R2
    (!dir_reg[0] |-> (pin_oe[0] && pin_o[0] == lat_reg[0])))
    else $error("output pin does not follow latch");
  a_port_input: assert property (@(posedge ref_clk) disable iff (sys_rst) // R2
    (dir_reg[4] |-> !pin_oe[4]))
    else $error("input pin driven");
  a_pin2_input: assert property (@(posedge ref_clk) disable iff (sys_rst) // R2
    (!sh_en[1] && dir_reg[2]) |-> !pin_oe[2])
    else $error("shared input pin driven");
  a_no_ovr_idle: assert property (@(posedge ref_clk) disable iff (sys_rst) // R4
    !serial2_active |-> (pin_oe == ~dir_reg && pin_o == lat_reg))
    else $error("pins overridden while serial idle");
  a_unshared: assert property (@(posedge ref_clk) disable iff (sys_rst) // R4
    (pin_oe[0] == !dir_reg[0] && pin_oe[3] == !dir_reg[3] && pin_oe[4] == !dir_reg[4]))
    else $error("unshared pin overridden");
  a_ovr_priority: assert property (@(posedge ref_clk) disable iff (sys_rst) // R10
    (sh_en[1] && sh_out[1]) |-> (pin_oe[2] && pin_o[2] == sh_dat[1]))
    else $error("serial data does not override latch");
  a_pin1_ovr: assert property (@(posedge ref_clk) disable iff (sys_rst) // R3 R10
    (sh_en[0] && sh_out[0]) |-> (pin_oe[1] == !(uod_reg[1] && sh_dat[0])))
    else $error("serial output on pin 1 wrong");
  a_od_low_only: assert property (@(posedge ref_clk) disable iff (sys_rst) // R3
    (uod_reg[1] && serial2_active && pin_oe[1]) |-> !pin_o[1])
    else $error("open-drain pin drives high");
  a_periph_force: assert property (@(posedge ref_clk) disable iff (sys_rst) // R4
    (sh_en[0] && !sh_out[0]) |-> !pin_oe[1])
    else $error("forced input still driven");

  c_write_port: cover property (@(posedge ref_clk) wr_en && paddr == `GPG_PORT_OFS);
  c_ovr_pin: cover property (@(posedge ref_clk) sh_en[0] && sh_out[0]);
  c_od_mode: cover property (@(posedge ref_clk) uod_reg[1] && serial2_active);
  c_bad_addr: cover property (@(posedge ref_clk) pslverr);
  c_rd_done: cover property (@(posedge ref_clk) state_reg == gpg_pkg::GPG_DONE && !pwrite);
endmodule
`default_nettype wire
